// ==== inc/card_port_pkg.sv ====
// Constants and types shared by the card host port and the socket-side end
package card_port_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int DATA_W = 16;
   localparam int MEM_AW = 16;
   localparam int REG_COUNT = 32;
   localparam int ATTR_OCTETS = 256;
   localparam int SYNC_STAGES = 2;
   localparam int FIFO_DEPTH = 16;
   localparam int BLOCK_WORDS = 64;

   // ---------------------------------------------------------------
   // Register map, byte offsets within the I/O window, then memory bases and reset values
   // ---------------------------------------------------------------
   localparam logic [5:0] OFS_BUF0_DATA = 6'h36;
   localparam logic [5:0] OFS_BUF1_DATA = 6'h38;
   localparam logic [5:0] OFS_BUF0_PTR = 6'h18;
   localparam logic [5:0] OFS_BUF1_PTR = 6'h1c;
   localparam logic [5:0] OFS_HW_FIRST = 6'h00;
   localparam logic [5:0] OFS_HW_LAST = 6'h0e;
   localparam logic [3:0] MASK_DEFAULT = 4'h0;
   localparam logic [MEM_AW-1:0] ATTR_BASE = 16'h0400;
   localparam logic [MEM_AW-1:0] REG_MEM_BASE = 16'h0000;
   localparam logic [MEM_AW-1:0] BUF_LIMIT_RST = 16'hffff;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

   // ---------------------------------------------------------------
   // Cycle kinds seen by the device after synchronisation
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      CYC_NONE,
      CYC_HW,
      CYC_MM,
      CYC_BUF0,
      CYC_BUF1,
      CYC_ATTR
   } cycle_kind_type;

endpackage : card_port_pkg

// ==== inc/card_bus_if.sv ====
// Card socket signals joining the host port and the socket-side end
`timescale 1ns/1ps
`default_nettype none
interface card_bus_if;
   logic [card_port_pkg::ADDR_W-1:0] host_addr;
   logic [card_port_pkg::DATA_W-1:0] data_from_socket;
   logic data_from_socket_oe;
   logic [card_port_pkg::DATA_W-1:0] data_from_card;
   logic data_from_card_oe;
   logic card_enable_low_n;
   logic card_enable_high_n;
   logic attr_write_strobe_n;
   logic attr_read_strobe_n;
   logic io_read_strobe_n;
   logic io_write_strobe_n;
   logic space_select_n;
   logic input_ack_n;
   logic wait_request_n;

   // Resolved data lines; either side may drive, never both
   wire [card_port_pkg::DATA_W-1:0] host_data_lines =
      data_from_card_oe ? data_from_card :
      (data_from_socket_oe ? data_from_socket : '0);

   modport card
   (
      input host_addr, host_data_lines, card_enable_low_n, card_enable_high_n,
      input attr_write_strobe_n, attr_read_strobe_n, io_read_strobe_n,
      input io_write_strobe_n, space_select_n,
      output data_from_card, data_from_card_oe, input_ack_n, wait_request_n
   );

   modport socket
   (
      output host_addr, data_from_socket, data_from_socket_oe,
      output card_enable_low_n, card_enable_high_n, attr_write_strobe_n,
      output attr_read_strobe_n, io_read_strobe_n, io_write_strobe_n,
      output space_select_n,
      input host_data_lines, input_ack_n, wait_request_n
   );
endinterface : card_bus_if
`default_nettype wire

// ==== rtl/word_fifo.sv ====
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // Fill side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // Drain side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0] count_r;
   logic push;
   logic pop;

   assign o_in_ready = (count_r != PW'(0) + (PW+1)'(DEPTH));
   assign o_out_valid = (count_r != '0);
   assign o_out_data = mem_r[rd_ptr_r];
   assign push = i_clk_en && i_in_valid && o_in_ready;
   assign pop = i_clk_en && o_out_valid && i_out_ready;

   always_ff @(posedge i_ref_clk)
   begin
      if (push)
      begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= PW'(wr_ptr_r + 1'b1);
         end
         if (pop)
         begin
            rd_ptr_r <= PW'(rd_ptr_r + 1'b1);
         end
         if (push && !pop)
         begin
            count_r <= (PW+1)'(count_r + 1'b1);
         end
         else if (pop && !push)
         begin
            count_r <= (PW+1)'(count_r - 1'b1);
         end
      end
   end
endmodule : word_fifo
`default_nettype wire

// ==== rtl/card_host_port.sv ====
// Card-side host port: cycle decode, wait/ack, posted writes, buffer pre-read
`timescale 1ns/1ps
`default_nettype none
module card_host_port
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // Socket pins
   card_bus_if.card bus,
   // Core status and configuration
   input wire logic i_init_done,
   input wire logic i_io_mode,
   input wire logic [3:0] i_addr_decode_mask,
   input wire logic [card_port_pkg::MEM_AW-1:0] i_buf0_limit,
   input wire logic [card_port_pkg::MEM_AW-1:0] i_buf1_limit,
   // Hardware register access
   output logic o_hw_we,
   output logic [4:0] o_hw_index,
   output logic [card_port_pkg::DATA_W-1:0] o_hw_wdata,
   output logic [1:0] o_hw_lanes,
   input wire logic [card_port_pkg::DATA_W-1:0] i_hw_rdata,
   // Memory arbitration port
   output logic o_mem_req,
   output logic o_mem_we,
   output logic [card_port_pkg::MEM_AW-1:0] o_mem_addr,
   output logic [card_port_pkg::DATA_W-1:0] o_mem_wdata,
   output logic [1:0] o_mem_lanes,
   input wire logic i_mem_gnt,
   input wire logic i_mem_done,
   input wire logic [card_port_pkg::DATA_W-1:0] i_mem_rdata,
   // Block chain lookup: next block start for a given block end
   output logic [card_port_pkg::MEM_AW-1:0] o_chain_addr,
   input wire logic [card_port_pkg::MEM_AW-1:0] i_chain_next
);
   localparam int DW = card_port_pkg::DATA_W;
   localparam int AW = card_port_pkg::MEM_AW;
   localparam int SS = card_port_pkg::SYNC_STAGES;
   localparam int WW = AW + DW + 2;

   typedef enum logic [2:0] {ST_IDLE, ST_MEMRD, ST_PRERD, ST_HOLD} state_type;
   typedef card_port_pkg::cycle_kind_type cycle_kind_type_alias;

   // ---------------------------------------------------------------
   // Strobe synchronisers
   // ---------------------------------------------------------------
   logic [SS-1:0] sync_r [7];
   logic [6:0] raw;
   logic [6:0] strb;
   assign raw = {~bus.card_enable_low_n, ~bus.card_enable_high_n, ~bus.space_select_n,
                 ~bus.io_read_strobe_n, ~bus.io_write_strobe_n,
                 ~bus.attr_read_strobe_n, ~bus.attr_write_strobe_n};
   genvar g;
   generate
      for (g = 0; g < 7; g++)
      begin : g_sync
         always_ff @(posedge i_ref_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               sync_r[g] <= '0;
            end
            else if (i_clk_en)
            begin
               sync_r[g] <= {sync_r[g][SS-2:0], raw[g]};
            end
         end
         assign strb[g] = sync_r[g][SS-1];
      end
   endgenerate

   logic ce1, ce2, sel, iord, iowr, aoe, awe;
   assign {ce1, ce2, sel, iord, iowr, aoe, awe} = strb;
   logic any_ce;
   logic io_cyc;
   logic attr_cyc;
   logic active;
   logic is_read;
   assign any_ce = ce1 || ce2;
   assign io_cyc = any_ce && sel && (iord ^ iowr) && i_init_done && i_io_mode;
   assign attr_cyc = any_ce && sel && (aoe ^ awe) && !bus.host_addr[0];
   assign active = io_cyc || attr_cyc;
   assign is_read = io_cyc ? iord : aoe;

   // Byte lanes: both enables word, low enable alone lets bit 0 pick the lane, high enable alone is the high lane
   logic [1:0] lanes;
   assign lanes = (ce1 && ce2) ? 2'b11 :
                  (ce1 ? (bus.host_addr[0] ? 2'b10 : 2'b01) : 2'b10);

   // Register decode
   logic [5:0] ofs;
   logic mask_ok;
   cycle_kind_type_alias kind;
   assign ofs = bus.host_addr[5:0];
   assign mask_ok = ((bus.host_addr[9:6] & i_addr_decode_mask) == 4'h0);
   always_comb
   begin
      kind = card_port_pkg::CYC_NONE;
      if (attr_cyc)
      begin
         kind = card_port_pkg::CYC_ATTR;
      end
      else if (io_cyc && mask_ok)
      begin
         if ({ofs[5:1], 1'b0} == card_port_pkg::OFS_BUF0_DATA)
            kind = card_port_pkg::CYC_BUF0;
         else if ({ofs[5:1], 1'b0} == card_port_pkg::OFS_BUF1_DATA)
            kind = card_port_pkg::CYC_BUF1;
         else if (ofs <= card_port_pkg::OFS_HW_LAST)
            kind = card_port_pkg::CYC_HW;
         else
            kind = card_port_pkg::CYC_MM;
      end
   end

   // ---------------------------------------------------------------
   // Posted write queue
   // ---------------------------------------------------------------
   logic wq_in_valid, wq_in_ready, wq_out_valid, wq_out_ready;
   logic [WW-1:0] wq_in_data, wq_out_data;
   word_fifo #(.WIDTH(WW), .DEPTH(card_port_pkg::FIFO_DEPTH)) u_wq
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_in_valid(wq_in_valid),
      .i_in_data(wq_in_data),
      .o_in_ready(wq_in_ready),
      .o_out_valid(wq_out_valid),
      .o_out_data(wq_out_data),
      .i_out_ready(wq_out_ready)
   );

   // ---------------------------------------------------------------
   // Cycle state
   // ---------------------------------------------------------------
   state_type state_r;
   logic [AW-1:0] ptr_r [2];
   logic [DW-1:0] pre_r;
   logic pre_valid_r;
   logic pre_port_r;
   logic [DW-1:0] rdata_r;
   logic wait_r;
   logic ack_r;
   logic rd_mem_r;
   logic [AW-1:0] rd_addr_r;
   logic buf_sel;
   logic is_buf;
   logic [AW-1:0] bptr;
   logic [AW-1:0] bptr_inc;
   logic [AW-1:0] blimit;
   logic [AW-1:0] cyc_addr;
   assign is_buf = (kind == card_port_pkg::CYC_BUF0) || (kind == card_port_pkg::CYC_BUF1);
   assign buf_sel = (kind == card_port_pkg::CYC_BUF1);
   assign bptr = ptr_r[buf_sel];
   assign blimit = buf_sel ? i_buf1_limit : i_buf0_limit;
   assign o_chain_addr = bptr;
   // Block end follows the chain; otherwise plain word step
   assign bptr_inc = (bptr[6:1] == 6'h3f) ? i_chain_next : AW'(bptr + 16'h0002);
   assign cyc_addr = (kind == card_port_pkg::CYC_ATTR) ?
                     AW'(card_port_pkg::ATTR_BASE + {6'h00, bus.host_addr[9:1], 1'b0}) :
                     (is_buf ? bptr : AW'(card_port_pkg::REG_MEM_BASE + {10'h000, ofs}));

   logic start;
   logic posted;
   assign start = (state_r == ST_IDLE) && (kind != card_port_pkg::CYC_NONE) && !wq_out_valid;
   assign posted = start && !is_read && (kind != card_port_pkg::CYC_HW)
                   && !(is_buf && bptr >= blimit);
   assign wq_in_valid = posted;
   assign wq_in_data = {lanes, cyc_addr, bus.host_data_lines};

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_r <= ST_IDLE;
         rdata_r <= card_port_pkg::DATA_RST;
         ack_r <= 1'b0;
         rd_mem_r <= 1'b0;
         rd_addr_r <= '0;
         ptr_r[0] <= '0;
         ptr_r[1] <= '0;
         pre_r <= card_port_pkg::DATA_RST;
         pre_valid_r <= 1'b0;
         pre_port_r <= 1'b0;
      end
      else if (i_clk_en)
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               if (start && !(posted && !wq_in_ready))
               begin
                  ack_r <= io_cyc && is_read;
                  if (is_buf)
                  begin
                     ptr_r[buf_sel] <= bptr_inc;
                  end
                  if (is_read && kind == card_port_pkg::CYC_HW)
                  begin
                     rdata_r <= i_hw_rdata;
                     state_r <= ST_HOLD;
                  end
                  else if (is_read && is_buf && pre_valid_r && pre_port_r == buf_sel)
                  begin
                     rdata_r <= pre_r;
                     rd_addr_r <= bptr_inc;
                     pre_valid_r <= 1'b0;
                     pre_port_r <= buf_sel;
                     state_r <= ST_PRERD;
                  end
                  else if (is_read)
                  begin
                     pre_valid_r <= 1'b0;
                     pre_port_r <= buf_sel;
                     rd_addr_r <= cyc_addr;
                     state_r <= ST_MEMRD;
                  end
                  else
                  begin
                     state_r <= ST_HOLD;
                  end
               end
            end
            ST_MEMRD:
            begin
               if (i_mem_done)
               begin
                  rdata_r <= i_mem_rdata;
                  if (is_buf)
                  begin
                     rd_addr_r <= bptr;
                     state_r <= ST_PRERD;
                  end
                  else
                  begin
                     state_r <= ST_HOLD;
                  end
               end
            end
            ST_PRERD:
            begin
               if (i_mem_done)
               begin
                  pre_r <= i_mem_rdata;
                  pre_valid_r <= 1'b1;
                  state_r <= ST_HOLD;
               end
            end
            ST_HOLD:
            begin
               ack_r <= 1'b0;
               if (!active)
               begin
                  state_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Wait low from cycle seen until read data is held
   always_comb
   begin
      wait_r = (state_r == ST_MEMRD)
               || (state_r == ST_IDLE && (kind != card_port_pkg::CYC_NONE));
   end

   // ---------------------------------------------------------------
   // Memory port: posted writes first, then reads
   // ---------------------------------------------------------------
   logic mem_rd;
   assign mem_rd = (state_r == ST_MEMRD) || (state_r == ST_PRERD);
   assign o_mem_req = wq_out_valid || mem_rd;
   assign o_mem_we = wq_out_valid;
   assign o_mem_addr = wq_out_valid ? wq_out_data[DW +: AW] : rd_addr_r;
   assign o_mem_wdata = wq_out_data[DW-1:0];
   assign o_mem_lanes = wq_out_valid ? wq_out_data[WW-1 -: 2] : 2'b11;
   // Done alone retires a write; the grant came cycles earlier
   assign wq_out_ready = i_mem_done;

   assign o_hw_we = start && !is_read && kind == card_port_pkg::CYC_HW && i_clk_en;
   assign o_hw_index = ofs[5:1];
   assign o_hw_wdata = bus.host_data_lines;
   assign o_hw_lanes = lanes;

   assign bus.data_from_card = rdata_r;
   assign bus.data_from_card_oe = (state_r == ST_HOLD || state_r == ST_PRERD) && is_read && active;
   assign bus.input_ack_n = !ack_r;
   assign bus.wait_request_n = !wait_r;
endmodule : card_host_port
`default_nettype wire

// ==== rtl/card_socket_end.sv ====
// Socket-controller end: runs one host cycle per request over the card pins
`timescale 1ns/1ps
`default_nettype none
module card_socket_end
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // Socket pins
   card_bus_if.socket bus,
   // User request
   input wire logic i_req_valid,
   output logic o_req_ready,
   input wire logic i_req_write,
   input wire logic i_req_attr,
   input wire logic [card_port_pkg::ADDR_W-1:0] i_req_addr,
   input wire logic [1:0] i_req_lanes,
   input wire logic [card_port_pkg::DATA_W-1:0] i_req_wdata,
   // User answer
   output logic o_rsp_valid,
   output logic [card_port_pkg::DATA_W-1:0] o_rsp_data
);
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_END} state_type;
   state_type state_r;
   logic write_r, attr_r;
   logic [card_port_pkg::ADDR_W-1:0] addr_r;
   logic [1:0] lanes_r;
   logic [card_port_pkg::DATA_W-1:0] wdata_r;
   logic wait_seen_r;

   assign o_req_ready = (state_r == ST_IDLE);

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_r <= ST_IDLE;
         write_r <= 1'b0;
         attr_r <= 1'b0;
         addr_r <= '0;
         lanes_r <= 2'b00;
         wdata_r <= card_port_pkg::DATA_RST;
         o_rsp_valid <= 1'b0;
         o_rsp_data <= card_port_pkg::DATA_RST;
         wait_seen_r <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_rsp_valid <= 1'b0;
         unique case (state_r)
            ST_IDLE:
            begin
               if (i_req_valid)
               begin
                  write_r <= i_req_write;
                  attr_r <= i_req_attr;
                  // Attribute space is even bytes only
                  addr_r <= i_req_attr ? {i_req_addr[9:1], 1'b0} : i_req_addr;
                  lanes_r <= i_req_lanes;
                  wdata_r <= i_req_wdata;
                  state_r <= ST_SETUP;
               end
            end
            ST_SETUP:
            begin
               wait_seen_r <= 1'b0;
               state_r <= ST_STROBE;
            end
            ST_STROBE:
            begin
               // Stay until the card has seen us and let go of wait
               if (!bus.wait_request_n)
               begin
                  wait_seen_r <= 1'b1;
               end
               else if (wait_seen_r)
               begin
                  o_rsp_data <= bus.host_data_lines;
                  o_rsp_valid <= !write_r;
                  state_r <= ST_END;
               end
            end
            ST_END:
            begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   logic strobe;
   logic cyc;
   assign strobe = (state_r == ST_STROBE);
   assign cyc = (state_r != ST_IDLE);
   assign bus.host_addr = addr_r;
   // Both enables for a word; one enable plus bit 0 for a byte
   assign bus.card_enable_low_n = !(cyc && (lanes_r == 2'b11 || lanes_r == 2'b01
                                  || (lanes_r == 2'b10 && addr_r[0])));
   assign bus.card_enable_high_n = !(cyc && (lanes_r == 2'b11
                                   || (lanes_r == 2'b10 && !addr_r[0])));
   assign bus.space_select_n = !cyc;
   assign bus.io_read_strobe_n = !(strobe && !attr_r && !write_r);
   assign bus.io_write_strobe_n = !(strobe && !attr_r && write_r);
   assign bus.attr_read_strobe_n = !(strobe && attr_r && !write_r);
   assign bus.attr_write_strobe_n = !(strobe && attr_r && write_r);
   assign bus.data_from_socket = wdata_r;
   assign bus.data_from_socket_oe = cyc && write_r;
endmodule : card_socket_end
`default_nettype wire

// ==== testbench/card_bus_checker.sv ====
// Assertions on the socket signals between the two ends
`timescale 1ns/1ps
`default_nettype none
module card_bus_checker
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Socket signals
   input wire logic [9:0] host_addr,
   input wire logic data_from_card_oe,
   input wire logic card_enable_low_n,
   input wire logic card_enable_high_n,
   input wire logic attr_read_strobe_n,
   input wire logic io_read_strobe_n,
   input wire logic io_write_strobe_n,
   input wire logic space_select_n,
   input wire logic input_ack_n,
   input wire logic wait_request_n
);
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   property p_sel_wait; !wait_request_n |-> !space_select_n; endproperty
   a_sel_wait: assert property (p_sel_wait) else $error("wait without select");
   property p_ack_cause;
      $fell(input_ack_n) |-> !io_read_strobe_n && !space_select_n
         && !card_enable_low_n && !card_enable_high_n;
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_ack_due; $fell(io_read_strobe_n) && !space_select_n |-> ##[1:20] !input_ack_n;
   endproperty
   a_ack_due: assert property (p_ack_due) else $error("missing ack");
   property p_ack_attr; !attr_read_strobe_n |-> input_ack_n; endproperty
   a_ack_attr: assert property (p_ack_attr) else $error("ack on attr read");
   property p_hw_wait;
      $fell(wait_request_n) && !io_read_strobe_n && host_addr[5:0] <= 6'h0e |=> wait_request_n;
   endproperty
   a_hw_wait: assert property (p_hw_wait) else $error("long hw wait");
   property p_post_wait; $fell(wait_request_n) && !io_write_strobe_n |=> wait_request_n;
   endproperty
   a_post_wait: assert property (p_post_wait) else $error("write not posted");
   property p_data_ready;
      $rose(wait_request_n) && (!io_read_strobe_n || !attr_read_strobe_n) |-> data_from_card_oe;
   endproperty
   a_data_ready: assert property (p_data_ready) else $error("wait ended without data");
   property p_wait_bound; $fell(wait_request_n) |-> ##[1:40] wait_request_n; endproperty
   a_wait_bound: assert property (p_wait_bound) else $error("wait too long");
   c_ack: cover property ($fell(input_ack_n));
   c_attr: cover property (!attr_read_strobe_n && !wait_request_n);
   c_write: cover property (!io_write_strobe_n && !wait_request_n);
endmodule : card_bus_checker
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench joining the socket end and the card host port
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0, rst_n = 1'b0, run = 1'b1, core_up = 1'b1, gnt = 1'b0, done = 1'b0;
   logic req_valid = 1'b0, req_ready, req_write = 1'b0, req_attr = 1'b0, rsp_valid;
   logic hw_we, mem_req, mem_we;
   logic [1:0] req_lanes = 2'h3, hw_lanes, mem_lanes, seen_lanes;
   logic [3:0] mask = 4'h0;
   logic [4:0] hw_index, seen_index;
   logic [9:0] req_addr = 10'h000;
   logic [15:0] lim = 16'hffff, hw_rdata = 16'h0000, mrd = 16'h0000, ma, req_wdata = 16'h0000;
   logic [15:0] rsp_data, hw_wdata, seen_wdata, mem_addr, mem_wdata, chain_addr;
   logic [15:0] mem [logic [15:0]];
   int error_cnt = 0, checked = 0, acks = 0, wcnt = 0, wlen = 0, mcnt = 0, wgr = 0;
   wire logic [15:0] chain_next = chain_addr + 16'h0080;
   always #5 clk = ~clk;
   card_bus_if bus ();
   card_socket_end u_card_socket_end (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(run),
      .bus(bus), .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req_write(req_write),
      .i_req_attr(req_attr), .i_req_addr(req_addr), .i_req_lanes(req_lanes),
      .i_req_wdata(req_wdata), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data));
   card_host_port u_card_host_port (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(run),
      .bus(bus), .i_init_done(core_up), .i_io_mode(core_up), .i_addr_decode_mask(mask),
      .i_buf0_limit(lim), .i_buf1_limit(lim), .o_hw_we(hw_we), .o_hw_index(hw_index),
      .o_hw_wdata(hw_wdata), .o_hw_lanes(hw_lanes), .i_hw_rdata(hw_rdata), .o_mem_req(mem_req),
      .o_mem_we(mem_we), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .o_mem_lanes(mem_lanes),
      .i_mem_gnt(gnt), .i_mem_done(done), .i_mem_rdata(mrd), .o_chain_addr(chain_addr),
      .i_chain_next(chain_next));
   card_bus_checker u_card_bus_checker (.i_ref_clk(clk), .i_rst_n(rst_n),
      .host_addr(bus.host_addr), .data_from_card_oe(bus.data_from_card_oe),
      .card_enable_low_n(bus.card_enable_low_n), .card_enable_high_n(bus.card_enable_high_n),
      .attr_read_strobe_n(bus.attr_read_strobe_n), .io_read_strobe_n(bus.io_read_strobe_n),
      .io_write_strobe_n(bus.io_write_strobe_n), .space_select_n(bus.space_select_n),
      .input_ack_n(bus.input_ack_n), .wait_request_n(bus.wait_request_n));
   // ---------------------------------------------------------------
   // Monitors and memory
   // ---------------------------------------------------------------
   always @(posedge clk)
   begin
      acks <= acks + int'(bus.input_ack_n === 1'b0);
      wcnt <= (bus.wait_request_n === 1'b0) ? wcnt + 1 : 0;
      if (bus.wait_request_n === 1'b1 && wcnt != 0) wlen <= wcnt;
      if (hw_we === 1'b1) {seen_index, seen_lanes, seen_wdata} <= {hw_index, hw_lanes, hw_wdata};
   end
   // Grant-to-done of two cycles, so a miss always shows three or more wait cycles
   always @(posedge clk)
   begin
      #1;
      gnt = 1'b0;
      done = (mcnt == 1);
      if (mcnt == 1) mrd = mem.exists(ma) ? mem[ma] : ma ^ 16'h5a5a;
      if (mcnt != 0) mcnt = mcnt - 1;
      else if (mem_req === 1'b1)
      begin
         {gnt, ma, mcnt} = {1'b1, mem_addr, 2};
         if (mem_we === 1'b1) mem[ma] = mem_wdata;
         wgr = wgr + int'(mem_we === 1'b1);
      end
   end
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : check
   task automatic acc(input logic wr, at, input logic [9:0] a, input logic [1:0] ln,
      input logic [15:0] wd, output logic [15:0] rd);
      {req_write, req_attr, req_addr, req_lanes, req_wdata, req_valid} = {wr, at, a, ln, wd, 1'b1};
      for (int n = 0; n < 100 && req_ready !== 1'b1; n++) @(posedge clk) #1;
      @(posedge clk) #1;
      req_valid = 1'b0;
      for (int n = 0; n < 200 && !wr && rsp_valid !== 1'b1; n++) @(posedge clk) #1;
      rd = rsp_data;
   endtask : acc
   task automatic rd_chk(input logic at, input logic [9:0] a, input logic [15:0] exp, string s);
      logic [15:0] d;
      acc(1'b0, at, a, 2'h3, 16'h0000, d);
      check({16'h0000, d}, {16'h0000, exp}, s);
   endtask : rd_chk
   task automatic t_hw;
      logic [15:0] d;
      hw_rdata = 16'hc3a1;
      rd_chk(1'b0, 10'h3c4, 16'hc3a1, "hw read");
      check(32'(acks), 32'h1, "ack count");
      for (int i = 1; i < 4; i++)
      begin
         acc(1'b1, 1'b0, 10'h006, 2'(i), 16'h71be, d);
         rd_chk(1'b0, 10'h000, 16'hc3a1, "hw sync");
         check({25'h0, seen_index, seen_lanes}, {25'h0, 5'h03, 2'(i)}, "hw write");
      end
      check({16'h0000, seen_wdata}, 32'h71be, "hw wdata");
   endtask : t_hw
   task automatic t_buf;
      logic [15:0] d;
      rd_chk(1'b0, 10'h036, 16'h5a5a, "buf0 first");
      rd_chk(1'b0, 10'h036, 16'h5a58, "buf0 next");
      check(32'(wlen < 3), 32'h1, "prefetch hit");
      rd_chk(1'b0, 10'h022, 16'h5a78, "mm read");
      rd_chk(1'b0, 10'h036, 16'h5a5e, "buf0 after mm");
      check(32'(wlen >= 3), 32'h1, "miss delay");
      rd_chk(1'b0, 10'h038, 16'h5a5a, "buf1 first");
      rd_chk(1'b0, 10'h036, 16'h5a5c, "buf0 after buf1");
      check(32'(wlen >= 3), 32'h1, "miss delay");
      lim = 16'h0000;
      acc(1'b1, 1'b0, 10'h038, 2'h3, 16'h2d2d, d);
      rd_chk(1'b0, 10'h000, 16'hc3a1, "sync");
      check(32'(wgr), 32'h0, "write past limit");
      lim = 16'hffff;
   endtask : t_buf
   task automatic t_mm;
      logic [15:0] d;
      acc(1'b1, 1'b0, 10'h020, 2'h3, 16'h1e5f, d);
      rd_chk(1'b0, 10'h020, 16'h1e5f, "posted then read");
      acc(1'b1, 1'b1, 10'h3fe, 2'h3, 16'h0c4d, d);
      rd_chk(1'b1, 10'h3fe, 16'h0c4d, "attr readback");
      rd_chk(1'b1, 10'h010, 16'h5e4a, "attr read");
      check({16'h0000, ma}, 32'h0410, "attr addr");
   endtask : t_mm
   // Posted queue exercised through the socket: back-to-back writes, then readback
   task automatic t_fifo;
      logic [15:0] d;
      acc(1'b1, 1'b0, 10'h024, 2'h3, 16'h3c21, d);
      acc(1'b1, 1'b0, 10'h026, 2'h3, 16'h4b12, d);
      rd_chk(1'b0, 10'h024, 16'h3c21, "queue first");
      rd_chk(1'b0, 10'h026, 16'h4b12, "queue second");
      check(32'(wgr), 32'h4, "posted count");
   endtask : t_fifo
   task automatic end_sim;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   initial
   begin
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_hw();
      t_buf();
      t_mm();
      t_fifo();
      end_sim();
   end
   initial
   begin
      #200us;
      error_cnt++;
      end_sim();
   end
endmodule : testbench
`default_nettype wire
